// ---- hdl/sysref_output_state_control.sv ----
// Register bank and decoded driver controls for eight reference outputs.
// Assumes a same-clock configuration port: one write or read per cycle,
// and a global bias-type level from the same clock domain.
`timescale 1ns/1ps

module sysref_output_state_control (
    input  wire logic               clk_in,
    input  wire logic               srst_in,
    input  wire logic [7:0]         addr_in,
    input  wire logic               wr_in,
    input  wire logic [7:0]         wdata_in,
    input  wire logic               rd_in,
    input  wire logic               bias_type_in,
    output logic      [7:0]         rdata_out,
    output logic      [7:0]         sel_sysref_out,
    output logic      [7:0][10:0]   delay_ps_out,
    output logic      [7:0]         bias_on_out,
    output logic      [7:0]         lvpecl_out,
    output logic      [7:0][9:0]    amp_mv_out,
    output logic      [7:0]         powered_out,
    output logic      [7:0]         drive_on_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0][7:0]  src_reg;
        logic [7:0][7:0]  drv_reg;
        logic [7:0]       en_reg;
        logic [7:0]       rdata;
        logic [7:0]       sel_sysref;
        logic [7:0][10:0] delay_ps;
        logic [7:0]       bias_on;
        logic [7:0]       lvpecl;
        logic [7:0][9:0]  amp_mv;
        logic [7:0]       powered;
        logic [7:0]       drive_on;
    } state_t;

    state_t st;
    state_t next_st;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Source and delay registers, one per output:
    //   A0 0x28, A1 0x29, A2 0x2a, B0 0x38, B1 0x39,
    //   C0 0x48, C1 0x49, D 0x58.
    //   [7]   reserved, written bits dropped, reads zero
    //   [6:5] fine delay code bits 1 and 0
    //   [4]   source select, 1 = SYSREF, 0 = channel clock
    //   [3:1] coarse delay code, 254 ps per step
    //   [0]   fine delay code bit 2
    // The fine code is split across the byte, so the decoder
    // rebuilds it as {bit 0, bits 6:5} before the table look-up.
    //
    // Driver settings registers sit four above their source
    // register (0x2c up to 0x5c):
    //   [7]   power-down, 1 = output off
    //   [6]   reserved
    //   [5]   crosspoint bias request
    //   [4]   format, 1 = LVPECL, 0 = LVDS
    //   [3:2] amplitude code, 250 mV per step from 250 mV
    //   [1:0] reserved
    //
    // Global enable register at 0x76: bit 7 enables A0 and
    // bit 0 enables D, so the index is flipped on decode.
    //
    // Every other address is unmapped: writes are ignored and
    // reads return zero. Reads see the value before a write in
    // the same cycle, which keeps the write data off the read
    // path and shortens the longest path through the bank.
    //
    // The bias request is not checked against the format here;
    // software must only set it on AC-coupled LVDS outputs, so
    // a wrong setting passes straight through to the driver.

    // ------------------------------------------------------------
    // Next state: register writes, readback and decoded controls
    // ------------------------------------------------------------
    // Reads return the value before a same-cycle write; decoded controls
    // follow the registers one cycle later so every output is a flop.
    always_comb begin
        next_st = st;
        next_st.rdata = 8'h00;  // Unmapped addresses read as zero
        for (int i = 0; i < sysref_out_pkg::NUM_OUT; i++) begin
            // Per-output copies at their own offsets
            if (wr_in && addr_in == sysref_out_pkg::SRC_OFS[i]) begin
                next_st.src_reg[i] = wdata_in & sysref_out_pkg::SRC_MASK;
            end
            if (wr_in && addr_in == sysref_out_pkg::SRC_OFS[i]
                    + sysref_out_pkg::DRV_DELTA) begin
                next_st.drv_reg[i] = wdata_in & sysref_out_pkg::DRV_MASK;
            end
            if (rd_in && addr_in == sysref_out_pkg::SRC_OFS[i]) begin
                next_st.rdata = st.src_reg[i];
            end
            if (rd_in && addr_in == sysref_out_pkg::SRC_OFS[i]
                    + sysref_out_pkg::DRV_DELTA) begin
                next_st.rdata = st.drv_reg[i];
            end
            next_st.sel_sysref[i] =
                st.src_reg[i][sysref_out_pkg::SRC_MUX];
            // Coarse steps plus non-linear fine table
            next_st.delay_ps[i] = 11'(st.src_reg[i][
                    sysref_out_pkg::SRC_COARSE_HI:
                    sysref_out_pkg::SRC_COARSE_LO])
                * sysref_out_pkg::COARSE_STEP_PS
                + sysref_out_pkg::FINE_PS[{
                    st.src_reg[i][sysref_out_pkg::SRC_FINE_MSB],
                    st.src_reg[i][sysref_out_pkg::SRC_FINE_HI:
                                  sysref_out_pkg::SRC_FINE_LO]}];
            // Bias only counts while the global bias type is set
            next_st.bias_on[i] = st.drv_reg[i][sysref_out_pkg::DRV_BIAS]
                && bias_type_in;
            next_st.powered[i] =
                !st.drv_reg[i][sysref_out_pkg::DRV_PD];
            next_st.lvpecl[i] = st.drv_reg[i][sysref_out_pkg::DRV_STYLE]
                && !st.drv_reg[i][sysref_out_pkg::DRV_PD];
            // Same scale in both formats; zero when powered down
            if (st.drv_reg[i][sysref_out_pkg::DRV_PD]) begin
                next_st.amp_mv[i] = 10'h000;
            end else begin
                next_st.amp_mv[i] = 10'(sysref_out_pkg::AMP_STEP_MV
                    * (10'(st.drv_reg[i][sysref_out_pkg::DRV_AMP_HI:
                                         sysref_out_pkg::DRV_AMP_LO])
                       + 10'h001));
            end
            // Enable bit order is A0 at the top
            next_st.drive_on[i] = st.en_reg[7 - i]
                && !st.drv_reg[i][sysref_out_pkg::DRV_PD];
        end
        if (wr_in && addr_in == sysref_out_pkg::EN_OFS) begin
            next_st.en_reg = wdata_in;
        end
        if (rd_in && addr_in == sysref_out_pkg::EN_OFS) begin
            next_st.rdata = st.en_reg;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Decoded outputs clear on reset and settle one cycle later.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st <= '0;
            st.src_reg <= {8{sysref_out_pkg::SRC_RESET}};
            st.drv_reg <= {8{sysref_out_pkg::DRV_RESET}};
            st.en_reg  <= sysref_out_pkg::EN_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_out      = st.rdata;
    assign sel_sysref_out = st.sel_sysref;
    assign delay_ps_out   = st.delay_ps;
    assign bias_on_out    = st.bias_on;
    assign lvpecl_out     = st.lvpecl;
    assign amp_mv_out     = st.amp_mv;
    assign powered_out    = st.powered;
    assign drive_on_out   = st.drive_on;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    // Register reset values, checked on the first cycle after reset
    reset_values_a: assert property ($past(srst_in) |->
        st.src_reg == {8{8'h10}} && st.drv_reg == '0 && st.en_reg == '0)
        else $error("Register bank reset values wrong");

    // Fields hold when nothing is written
    field_hold_a: assert property (!wr_in |=>
        $stable(st.src_reg) && $stable(st.drv_reg) && $stable(st.en_reg))
        else $error("Register changed without a write");

    // Unmapped read answers zero
    unmapped_read_a: assert property (rd_in && addr_in == 8'h30 |=>
        rdata_out == 8'h00)
        else $error("Unmapped read not zero");

    // Enable register write and readback
    en_readback_a: assert property (wr_in && addr_in == 8'h76 ##1
        rd_in && addr_in == 8'h76 && !wr_in |=>
        rdata_out == $past(wdata_in, 2))
        else $error("Enable register readback mismatch");

    // Global bias type low forces every bias off
    bias_gate_a: assert property (!bias_type_in |=>
        bias_on_out == 8'h00)
        else $error("Bias active with bias type clear");

    for (genvar g = 0; g < 8; g++) begin : g_chk
        // Source register write then readback over two cycles
        src_readback_a: assert property (wr_in &&
            addr_in == sysref_out_pkg::SRC_OFS[g] ##1
            rd_in && !wr_in && addr_in == sysref_out_pkg::SRC_OFS[g] |=>
            rdata_out == ($past(wdata_in, 2) & 8'h7f))
            else $error("Source register readback mismatch");

        // Delay output two cycles after a source write
        delay_value_a: assert property (wr_in &&
            addr_in == sysref_out_pkg::SRC_OFS[g] ##1 !wr_in |=>
            delay_ps_out[g] == 11'($past(wdata_in, 2) >> 1 & 8'h07)
                * 11'h0fe + sysref_out_pkg::FINE_PS[{
                $past(wdata_in[0], 2), $past(wdata_in[6:5], 2)}]
            && sel_sysref_out[g] == $past(wdata_in[4], 2))
            else $error("Delay or source output wrong");

        // Power-down voids amplitude, format and enable
        pd_kill_a: assert property (st.drv_reg[g][7] |=>
            amp_mv_out[g] == 10'd0 && !lvpecl_out[g] && !drive_on_out[g]
            && !powered_out[g])
            else $error("Powered-down output still active");

        // Enable bit order A0 at bit 7
        en_order_a: assert property (!st.en_reg[7 - g] |=>
            !drive_on_out[g])
            else $error("Disabled output not held low");

        // Amplitude scale while powered
        amp_scale_a: assert property (!st.drv_reg[g][7] |=>
            amp_mv_out[g] == 10'd250 * ({8'h00, $past(st.drv_reg[g][3:2])}
            + 10'd1))
            else $error("Amplitude value wrong");

        // Format follows the style bit while powered
        style_a: assert property (!st.drv_reg[g][7] |=>
            lvpecl_out[g] == $past(st.drv_reg[g][4]))
            else $error("Format output wrong");

        // Source select follows its register bit
        sel_follow_a: assert property (1'b1 |=>
            sel_sysref_out[g] == $past(st.src_reg[g][4]))
            else $error("Source select output wrong");

        // Bias passes through while the global bias type is set
        bias_pass_a: assert property (bias_type_in &&
            st.drv_reg[g][5] |=> bias_on_out[g])
            else $error("Bias missing with bias type set");

        // Enabled and powered output drives
        drive_on_a: assert property (st.en_reg[7 - g] &&
            !st.drv_reg[g][7] |=> drive_on_out[g])
            else $error("Enabled output not driving");

        // Power-down bit clear means powered up
        powered_up_a: assert property (!st.drv_reg[g][7] |=>
            powered_out[g])
            else $error("Output powered down without request");

        // Reserved source bit dropped on write
        src_reserved_a: assert property (wr_in &&
            addr_in == sysref_out_pkg::SRC_OFS[g] |=>
            !st.src_reg[g][7])
            else $error("Reserved source bit stored");

        // Reserved driver bits dropped on write
        drv_reserved_a: assert property (wr_in &&
            addr_in == sysref_out_pkg::SRC_OFS[g]
            + sysref_out_pkg::DRV_DELTA |=>
            (st.drv_reg[g] & 8'h43) == 8'h00)
            else $error("Reserved driver bits stored");

        // Delay never exceeds the largest coarse plus fine sum
        delay_range_a: assert property (
            delay_ps_out[g] <= 11'h792)
            else $error("Delay out of range");
    end

    // Read data stands one cycle only, then returns to zero
    rdata_idle_a: assert property (!rd_in |=>
        rdata_out == 8'h00)
        else $error("Read data not zero outside a read");

    // Main scenarios
    cover_lvpecl_c: cover property (lvpecl_out[0] && amp_mv_out[0] ==
        10'd1000);
    cover_bias_c: cover property (bias_on_out[7]);
    cover_max_delay_c: cover property (delay_ps_out[3] == 11'd1938);
    cover_all_on_c: cover property (drive_on_out == 8'hff);

endmodule // sysref_output_state_control

// ---- hdl/sysref_out_pkg.sv ----
// Constants for the reference output state control bank: offsets,
// field positions, reset values and delay and amplitude steps.
// Assumes an 8-bit configuration port with 8-bit register addresses.
package sysref_out_pkg;

    // ------------------------------------------------------------
    // Bank shape
    // ------------------------------------------------------------
    localparam int NUM_OUT = 8;

    // ------------------------------------------------------------
    // Register offsets, index 0 = A0 ... index 7 = D
    // ------------------------------------------------------------
    localparam logic [7:0][7:0] SRC_OFS = {8'h58, 8'h49, 8'h48, 8'h39,
                                           8'h38, 8'h2a, 8'h29, 8'h28};
    localparam logic [7:0] DRV_DELTA = 8'h04;  // Driver reg = source + 4
    localparam logic [7:0] EN_OFS    = 8'h76;

    // ------------------------------------------------------------
    // Source and delay register fields
    // ------------------------------------------------------------
    localparam int SRC_FINE_HI   = 6;  // Fine delay bits [1:0]
    localparam int SRC_FINE_LO   = 5;
    localparam int SRC_MUX       = 4;
    localparam int SRC_COARSE_HI = 3;
    localparam int SRC_COARSE_LO = 1;
    localparam int SRC_FINE_MSB  = 0;  // Fine delay bit [2]
    localparam logic [7:0] SRC_MASK  = 8'h7f;
    localparam logic [7:0] SRC_RESET = 8'h10;  // Source is SYSREF

    // ------------------------------------------------------------
    // Driver settings register fields
    // ------------------------------------------------------------
    localparam int DRV_PD     = 7;
    localparam int DRV_BIAS   = 5;
    localparam int DRV_STYLE  = 4;
    localparam int DRV_AMP_HI = 3;
    localparam int DRV_AMP_LO = 2;
    localparam logic [7:0] DRV_MASK  = 8'hbc;
    localparam logic [7:0] DRV_RESET = 8'h00;
    localparam logic [7:0] EN_RESET  = 8'h00;

    // ------------------------------------------------------------
    // Delay and amplitude scales
    // ------------------------------------------------------------
    localparam logic [10:0] COARSE_STEP_PS = 11'h0fe;  // 254 ps
    localparam logic [7:0][10:0] FINE_PS = {
        11'h0a0, 11'h087, 11'h06e, 11'h055,   // 160 135 110 85
        11'h04b, 11'h032, 11'h019, 11'h000};  // 75 50 25 0
    localparam logic [9:0] AMP_STEP_MV = 10'h0fa;  // 250 mV

endpackage

// ---- tb/converter_model.sv ----
// Far-side converter seen as a load on the eight reference outputs.
// Assumes decoded driver controls arrive as registered levels.
`timescale 1ns/1ps

module converter_model (
    input  wire logic [7:0] lvpecl_in,
    input  wire logic [7:0] bias_on_in,
    output logic            misuse_out
);
    // A biased output must be LVDS; a biased LVPECL input would be damaged
    assign misuse_out = |(bias_on_in & lvpecl_in);
endmodule  // converter_model

// ---- tb/sysref_output_state_control_tb.sv ----
// Bench for the reference output bank: register tasks and checks.
// Assumes the bank and the converter model are compiled alongside.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %h got %h", n, e, g); fail_count++; end end

module sysref_output_state_control_tb;
    logic              clk_in, srst_in, wr_in, rd_in, bias_type_in;
    logic [7:0]        addr_in, wdata_in, rdata_out, sel_sysref_out;
    logic [7:0]        bias_on_out, lvpecl_out, powered_out, drive_on_out;
    logic [7:0][10:0]  delay_ps_out;
    logic [7:0][9:0]   amp_mv_out;
    logic              misuse;
    logic [2:0]        c, f;
    logic [7:0]        w;
    logic [10:0]       d;
    int                fail_count, cmp_count, i;
    int                fine_ps [8] = '{0, 25, 50, 75, 85, 110, 135, 160};

    sysref_output_state_control u_dut (.clk_in(clk_in), .srst_in(srst_in),
        .addr_in(addr_in), .wr_in(wr_in), .wdata_in(wdata_in),
        .rd_in(rd_in), .bias_type_in(bias_type_in), .rdata_out(rdata_out),
        .sel_sysref_out(sel_sysref_out), .delay_ps_out(delay_ps_out),
        .bias_on_out(bias_on_out), .lvpecl_out(lvpecl_out),
        .amp_mv_out(amp_mv_out), .powered_out(powered_out),
        .drive_on_out(drive_on_out));
    converter_model u_conv (.lvpecl_in(lvpecl_out),
        .bias_on_in(bias_on_out), .misuse_out(misuse));

    // ------------------------------------------------------------
    // Clock and register port tasks
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Each access leaves a spare edge so strobes never re-assert in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        @(posedge clk_in);
        #1 wr_in = 1'b0;
        @(posedge clk_in);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr_in = a;
        rd_in = 1'b1;
        @(posedge clk_in);
        #1 rd_in = 1'b0;
        `CHK("rdata", e, rdata_out)
        @(posedge clk_in);
        #1;
    endtask

    // Decoded outputs settle one edge after a register changes
    task automatic settle;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #50000;
        fail_count++;
        conclude;
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {wr_in, rd_in, bias_type_in, addr_in, wdata_in} = '0;
        srst_in = 1'b1;
        repeat (20) @(posedge clk_in);
        #1 srst_in = 1'b0;
        settle;
        `CHK("sel", 8'hff, sel_sysref_out)
        `CHK("pwr", 8'hff, powered_out)
        `CHK("drive", 8'h00, drive_on_out)
        `CHK("fmt", 8'h00, lvpecl_out)
        for (i = 0; i < 8; i++) begin
            `CHK("amp", 10'h0fa, amp_mv_out[i])
            `CHK("dly", 11'h000, delay_ps_out[i])
            rd(sysref_out_pkg::SRC_OFS[i], 8'h10);
            rd(sysref_out_pkg::SRC_OFS[i] + sysref_out_pkg::DRV_DELTA,
               8'h00);
        end
        rd(8'h76, 8'h00);
        // Distinct delay codes per output; reserved bit 7 written high
        for (i = 0; i < 8; i++)
            wr(sysref_out_pkg::SRC_OFS[i], {1'b1, 2'(7 - i), i[0],
               i[2:0], 1'(((7 - i) >> 2) & 1)});
        settle;
        for (i = 0; i < 8; i++) begin
            c = i[2:0];
            f = 3'(7 - i);
            w = {1'b0, f[1:0], i[0], c, f[2]};
            d = 11'(c * 254 + fine_ps[f]);
            `CHK("dly", d, delay_ps_out[i])
            `CHK("sel", i[0], sel_sysref_out[i])
            rd(sysref_out_pkg::SRC_OFS[i], w);
        end
        // Bias only on LVDS outputs, as the configuring side must keep
        for (i = 0; i < 8; i++)
            wr(sysref_out_pkg::SRC_OFS[i] + sysref_out_pkg::DRV_DELTA,
               {2'b01, ~i[2], i[2], i[1:0], 2'b11});
        wr(8'h76, 8'hc1);
        settle;
        for (i = 0; i < 8; i++) begin
            `CHK("amp", 10'((i % 4 + 1) * 250), amp_mv_out[i])
            rd(sysref_out_pkg::SRC_OFS[i] + sysref_out_pkg::DRV_DELTA,
               {2'b00, ~i[2], i[2], i[1:0], 2'b00});
        end
        `CHK("fmt", 8'hf0, lvpecl_out)
        `CHK("drive", 8'h83, drive_on_out)
        `CHK("bias", 8'h00, bias_on_out)
        bias_type_in = 1'b1;
        settle;
        `CHK("bias", 8'h0f, bias_on_out)
        `CHK("misuse", 1'b0, misuse)
        // Power-down voids format, enable and amplitude, keeps fields
        wr(8'h2c, 8'h9c);
        settle;
        `CHK("pwr", 8'hfe, powered_out)
        `CHK("amp", 10'h000, amp_mv_out[0])
        `CHK("fmt", 8'hf0, lvpecl_out)
        `CHK("drive", 8'h82, drive_on_out)
        rd(8'h2c, 8'h9c);
        wr(8'h2c, 8'h1c);
        settle;
        `CHK("amp", 10'h3e8, amp_mv_out[0])
        `CHK("drive", 8'h83, drive_on_out)
        // Unmapped place reads as zero
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        // Reset in mid-run returns stored fields to defaults
        srst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 srst_in = 1'b0;
        rd(8'h28, 8'h10);
        rd(8'h76, 8'h00);
        conclude;
    end
endmodule  // sysref_output_state_control_tb
